// file: hdl/ee_slave.sv
/*
  two-wire serial memory slave, 16 bytes of 8 bits, with byte write,
  self-timed write cycle, acknowledge polling and three read forms.
  assumes scl and sda arrive from the bus asynchronously, sda is an
  open-drain line resolved outside, and the master owns the clock.
*/
// Summary of operation
// - a write starts with START, device code, three ignored bits, rw low
// - a matching control byte is acknowledged unless a write cycle runs
// - the byte after a write control byte loads the address pointer
// - only the low four address bits count, upper four are ignored
// - address and data bytes are acknowledged, then the master sends STOP
// - STOP after a full byte write starts the write cycle, acks withheld
// - after a byte write the pointer stays at the written address
// - STOP before the write sequence completes abandons it, nothing stored
// - extra whole data bytes replace the loaded byte and refill the buffer
// - STOP inside a later partial data byte aborts, nothing stored
// - polling is not acknowledged while busy, acknowledged once done
// - rw high selects a read; current, random and sequential reads exist
// - after a read the pointer holds last read address plus one
// - a read control byte is acked, then data goes out msb first
// - master nacks and sends STOP to end a read; device stops sending
// - random read is a cut-short write then a read; pointer is kept
// - after a random read the pointer is at the next location
// - each master ack in a sequential read fetches the next byte
// - the pointer increments by one at the end of each byte read
// - the upper four control bits are compared, next three ignored
// - START is sda falling with scl high, STOP sda rising with scl high
// - on a master nack the device releases sda high
`timescale 1ns/100ps
module ee_slave #(
  parameter logic [3:0] DEV_CODE   = ee_pkg::DEV_CODE_DEF,
  parameter int         TWC_CYCLES = ee_pkg::TWC_CYCLES,
  parameter int         FIFO_DEPTH = ee_pkg::FIFO_DEPTH
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  output logic      wr_busy
);

  logic                rst_meta_reg;
  logic                rst_sync_n_reg;
  logic                scl_meta_reg, scl_sync_reg, scl_dly_reg;
  logic                sda_meta_reg, sda_sync_reg, sda_dly_reg;
  logic                scl_rise, scl_fall, start_det, stop_det;
  ee_pkg::ee_state_e   state_reg;
  ee_pkg::ee_role_e    role_reg;
  logic [3:0]          bitcnt_reg;
  logic [3:0]          txcnt_reg;
  logic [7:0]          shift_reg;
  logic [7:0]          rx_next;
  logic [7:0]          tx_shift_reg;
  logic [7:0]          data_buf_reg;
  logic                have_data_reg;
  logic                rw_reg;
  logic                ack_half_reg;
  logic                sda_oe_reg;
  logic                sda_out_reg;
  logic                wr_busy_reg;
  logic [3:0]          ptr_reg;
  logic [7:0]          mem [ee_pkg::MEM_WORDS];
  logic [7:0]          mem_rd;
  logic                bus_evt;
  logic                byte_done, tx_load, tx_done, ctrl_ok, busy_now;
  logic                commit_ok;
  logic                push_reg;
  ee_pkg::ee_wreq_s    wreq_reg;
  logic                fifo_in_ready;
  logic                fifo_out_valid;
  ee_pkg::ee_wreq_s    fifo_out;
  logic                eng_busy_reg;
  logic                eng_start;
  logic [31:0]         eng_cnt_reg;

  // reset release through two flops, assertion stays asynchronous
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg   <= 1'b0;
      rst_sync_n_reg <= 1'b0;
    end else begin
      rst_meta_reg   <= 1'b1;
      rst_sync_n_reg <= rst_meta_reg;
    end
  end

  // bus lines idle high; the meta flops feed only the sync flops
  always_ff @(posedge clock or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      scl_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      scl_dly_reg  <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      sda_dly_reg  <= 1'b1;
    end else begin
      scl_meta_reg <= scl_in;
      scl_sync_reg <= scl_meta_reg;
      scl_dly_reg  <= scl_sync_reg;
      sda_meta_reg <= sda_in;
      sda_sync_reg <= sda_meta_reg;
      sda_dly_reg  <= sda_sync_reg;
    end
  end

  // edges and bus conditions, seen anywhere in a transfer
  assign scl_rise  = scl_sync_reg && !scl_dly_reg;
  assign scl_fall  = !scl_sync_reg && scl_dly_reg;
  assign start_det = scl_sync_reg && scl_dly_reg &&
                     sda_dly_reg && !sda_sync_reg;
  assign stop_det  = scl_sync_reg && scl_dly_reg &&
                     !sda_dly_reg && sda_sync_reg;
  assign bus_evt   = start_det || stop_det;

  // decode of the byte being completed and of transmit steps
  assign rx_next   = {shift_reg[6:0], sda_sync_reg};
  assign mem_rd    = mem[ptr_reg];
  assign busy_now  = eng_busy_reg || fifo_out_valid || push_reg ||
                     !fifo_in_ready;
  assign ctrl_ok   = (rx_next[ee_pkg::CODE_MSB:ee_pkg::CODE_LSB] ==
                      DEV_CODE) && !busy_now;
  assign byte_done = !bus_evt && state_reg == ee_pkg::S_RX && scl_rise &&
                     bitcnt_reg == 4'(ee_pkg::LAST_BIT);
  assign tx_load   = !bus_evt && scl_fall &&
                     ((state_reg == ee_pkg::S_ACK && ack_half_reg &&
                       role_reg == ee_pkg::B_CTRL && rw_reg) ||
                      state_reg == ee_pkg::S_TXLD);
  assign tx_done   = !bus_evt && scl_fall && state_reg == ee_pkg::S_TX &&
                     txcnt_reg == 4'(ee_pkg::BYTE_BITS);
  // a whole data byte and no loose bits after it; the stop's own scl
  // rise is always counted as one bit, so a clean stop leaves one
  assign commit_ok = state_reg == ee_pkg::S_RX &&
                     role_reg == ee_pkg::B_DATA && have_data_reg &&
                     bitcnt_reg == 4'h1;

  // protocol engine; start and stop override whatever is in progress
  always_ff @(posedge clock or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      state_reg     <= ee_pkg::S_IDLE;
      role_reg      <= ee_pkg::B_CTRL;
      bitcnt_reg    <= ee_pkg::CNT_RST;
      txcnt_reg     <= ee_pkg::CNT_RST;
      shift_reg     <= ee_pkg::BYTE_RST;
      tx_shift_reg  <= ee_pkg::BYTE_RST;
      data_buf_reg  <= ee_pkg::BYTE_RST;
      have_data_reg <= 1'b0;
      rw_reg        <= 1'b0;
      ack_half_reg  <= 1'b0;
      sda_oe_reg    <= 1'b0;
    end else if (start_det) begin
      state_reg     <= ee_pkg::S_RX;
      role_reg      <= ee_pkg::B_CTRL;
      bitcnt_reg    <= ee_pkg::CNT_RST;
      have_data_reg <= 1'b0;
      ack_half_reg  <= 1'b0;
      sda_oe_reg    <= 1'b0;
    end else if (stop_det) begin
      state_reg     <= ee_pkg::S_IDLE;
      have_data_reg <= 1'b0;
      ack_half_reg  <= 1'b0;
      sda_oe_reg    <= 1'b0;
    end else begin
      case (state_reg)
        ee_pkg::S_IDLE: begin
          sda_oe_reg <= 1'b0;
        end
        ee_pkg::S_RX: begin
          if (scl_rise) begin
            shift_reg <= rx_next;
            if (bitcnt_reg == 4'(ee_pkg::LAST_BIT)) begin
              bitcnt_reg <= ee_pkg::CNT_RST;
              case (role_reg)
                ee_pkg::B_CTRL: begin
                  if (ctrl_ok) begin
                    rw_reg    <= rx_next[ee_pkg::RW_BIT];
                    state_reg <= ee_pkg::S_ACK;
                  end else begin
                    state_reg <= ee_pkg::S_IDLE;
                  end
                end
                ee_pkg::B_ADDR: begin
                  role_reg  <= ee_pkg::B_DATA;
                  state_reg <= ee_pkg::S_ACK;
                end
                default: begin
                  // a later byte simply replaces the earlier one
                  data_buf_reg  <= rx_next;
                  have_data_reg <= 1'b1;
                  state_reg     <= ee_pkg::S_ACK;
                end
              endcase
            end else begin
              bitcnt_reg <= bitcnt_reg + 4'h1;
            end
          end
        end
        ee_pkg::S_ACK: begin
          if (scl_fall) begin
            if (!ack_half_reg) begin
              sda_oe_reg   <= 1'b1;
              ack_half_reg <= 1'b1;
            end else begin
              ack_half_reg <= 1'b0;
              if (role_reg == ee_pkg::B_CTRL && rw_reg) begin
                sda_oe_reg   <= !mem_rd[7];
                tx_shift_reg <= {mem_rd[6:0], 1'b0};
                txcnt_reg    <= 4'h1;
                state_reg    <= ee_pkg::S_TX;
              end else begin
                sda_oe_reg <= 1'b0;
                state_reg  <= ee_pkg::S_RX;
                if (role_reg == ee_pkg::B_CTRL) begin
                  role_reg <= ee_pkg::B_ADDR;
                end
              end
            end
          end
        end
        ee_pkg::S_TX: begin
          if (scl_fall) begin
            if (txcnt_reg != 4'(ee_pkg::BYTE_BITS)) begin
              sda_oe_reg   <= !tx_shift_reg[7];
              tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
              txcnt_reg    <= txcnt_reg + 4'h1;
            end else begin
              sda_oe_reg <= 1'b0;                        // master's ack slot
              state_reg  <= ee_pkg::S_TXACK;
            end
          end
        end
        ee_pkg::S_TXACK: begin
          if (scl_rise) begin
            // a high level is a nack: stay off the line until stop
            state_reg <= sda_sync_reg ? ee_pkg::S_IDLE
                                      : ee_pkg::S_TXLD;
          end
        end
        ee_pkg::S_TXLD: begin
          if (scl_fall) begin
            sda_oe_reg   <= !mem_rd[7];
            tx_shift_reg <= {mem_rd[6:0], 1'b0};
            txcnt_reg    <= 4'h1;
            state_reg    <= ee_pkg::S_TX;
          end
        end
        default: begin
          state_reg  <= ee_pkg::S_IDLE;
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  // address pointer: loaded by a write, advanced by each byte read
  always_ff @(posedge clock or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      ptr_reg <= ee_pkg::PTR_RST;
    end else if (byte_done && role_reg == ee_pkg::B_ADDR) begin
      ptr_reg <= rx_next[ee_pkg::ADDR_BITS-1:0];
    end else if (tx_done) begin
      ptr_reg <= ptr_reg + 4'h1;
    end
  end

  // write request on a clean stop; the pointer is left alone here
  always_ff @(posedge clock or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      push_reg <= 1'b0;
      wreq_reg <= '0;
    end else begin
      push_reg      <= stop_det && commit_ok && fifo_in_ready;
      wreq_reg.addr <= ptr_reg;
      wreq_reg.data <= data_buf_reg;
    end
  end

  // the programming engine drains this; a full fifo counts as busy
  ee_fifo #(
    .WIDTH ($bits(ee_pkg::ee_wreq_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_wfifo (
    .clock     (clock),
    .rst_n     (rst_sync_n_reg),
    .in_valid  (push_reg),
    .in_ready  (fifo_in_ready),
    .in_data   (wreq_reg),
    .out_valid (fifo_out_valid),
    .out_ready (!eng_busy_reg),
    .out_data  (fifo_out)
  );

  assign eng_start = !eng_busy_reg && fifo_out_valid;

  // self-timed write cycle; the array cell changes when it starts
  always_ff @(posedge clock or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      eng_busy_reg <= 1'b0;
      eng_cnt_reg  <= '0;
    end else if (eng_start) begin
      eng_busy_reg <= 1'b1;
      eng_cnt_reg  <= 32'(TWC_CYCLES - 1);
    end else if (eng_busy_reg) begin
      if (eng_cnt_reg == '0) begin
        eng_busy_reg <= 1'b0;
      end else begin
        eng_cnt_reg <= eng_cnt_reg - 32'h1;
      end
    end
  end

  // array content has no reset value, as in the real cells
  always_ff @(posedge clock) begin
    if (eng_start) begin
      mem[fifo_out.addr] <= fifo_out.data;
    end
  end

  // registered pins; the data pin only ever pulls low
  always_ff @(posedge clock or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      sda_out_reg <= 1'b0;
      wr_busy_reg <= 1'b0;
    end else begin
      sda_out_reg <= 1'b0;
      wr_busy_reg <= busy_now;
    end
  end

  assign sda_out = sda_out_reg;
  assign sda_oe  = sda_oe_reg;
  assign wr_busy = wr_busy_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_sync_n_reg);

  sequence nack_seen;
    state_reg == ee_pkg::S_TXACK && scl_rise && sda_sync_reg && !bus_evt;
  endsequence

  sequence line_released;
    state_reg == ee_pkg::S_IDLE && !sda_oe_reg;
  endsequence

  sequence ctrl_busy;
    byte_done && role_reg == ee_pkg::B_CTRL && busy_now;
  endsequence

  busy_no_ack_a: assert property (ctrl_busy |=> line_released ##1
                                  !sda_oe_reg)
    else $error("control byte acknowledged during write cycle");

  match_ack_a: assert property (byte_done && role_reg == ee_pkg::B_CTRL
      && ctrl_ok |=> state_reg == ee_pkg::S_ACK && !sda_oe_reg)
    else $error("matching control byte not taken for acknowledge");

  ptr_load_a: assert property (byte_done && role_reg == ee_pkg::B_ADDR
      |=> ptr_reg == $past(rx_next[3:0]))
    else $error("pointer not loaded from low address bits");

  commit_cause_a: assert property (push_reg |->
      $past(stop_det) && $past(commit_ok))
    else $error("write request without a clean stop");

  ptr_hold_a: assert property (push_reg |-> ptr_reg == wreq_reg.addr)
    else $error("pointer moved after byte write");

  ptr_incr_a: assert property (tx_done |=>
      ptr_reg == $past(ptr_reg) + 4'h1)
    else $error("pointer not advanced after byte read");

  msb_first_a: assert property (tx_load |=>
      sda_oe_reg == !$past(mem_rd[7]) && txcnt_reg == 4'h1)
    else $error("read data does not start with msb");

  start_rx_a: assert property (start_det |=>
      state_reg == ee_pkg::S_RX && bitcnt_reg == 4'h0 && !sda_oe_reg)
    else $error("start not recognised");

  nack_release_a: assert property (nack_seen |=> line_released[*2])
    else $error("sda not released after master nack");

  wcycle_len_a: assert property (eng_start |=> eng_busy_reg[*8])
    else $error("write cycle ended too early");

endmodule : ee_slave

// file: hdl/ee_pkg.sv
/*
  constants, types and state encodings shared by the 16-byte two-wire
  serial memory slave, its write-request fifo and its top level.
  assumes a 100 MHz system clock; the bus lines arrive asynchronously.
*/
package ee_pkg;

  // system clock and the self-timed write cycle
  localparam int CLK_MHZ     = 100;
  localparam int TWC_MS      = 4;                      // write cycle, ms
  localparam int TWC_CYCLES  = TWC_MS * 1000 * CLK_MHZ; // 400000 cycles

  // array geometry
  localparam int BYTE_BITS   = 8;
  localparam int ADDR_BITS   = 4;
  localparam int MEM_WORDS   = 16;
  localparam int FIFO_DEPTH  = 16;

  // control byte layout
  localparam int CODE_MSB    = 7;
  localparam int CODE_LSB    = 4;
  localparam int RW_BIT      = 0;
  localparam int LAST_BIT    = 7;                      // bit index of bit 8

  // value is arbitrary, set the real device-type code per product
  localparam logic [3:0] DEV_CODE_DEF = 4'h5;

  // values after reset
  localparam logic [3:0] PTR_RST = 4'h0;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;

  typedef enum {
    S_IDLE, S_RX, S_ACK, S_TX, S_TXACK, S_TXLD
  } ee_state_e;

  // which byte of a command is being received
  typedef enum {
    B_CTRL, B_ADDR, B_DATA
  } ee_role_e;

  // one pending array write
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] data;
  } ee_wreq_s;

endpackage : ee_pkg

// file: hdl/ee_fifo.sv
/*
  synchronous valid/ready fifo with parameter width and depth.
  assumes one clock and an active-low reset already synchronised.
*/
`timescale 1ns/100ps
module ee_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  logic             push;
  logic             pop;

  // full when the pointers differ only in the wrap bit
  assign in_ready  = (wr_ptr_reg[AW] == rd_ptr_reg[AW]) ||
                     (wr_ptr_reg[AW-1:0] != rd_ptr_reg[AW-1:0]);
  assign out_valid = (wr_ptr_reg != rd_ptr_reg);
  assign out_data  = store[rd_ptr_reg[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage carries no reset, only the pointers need one
  always_ff @(posedge clock) begin
    if (push) begin
      store[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + (AW+1)'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + (AW+1)'(1);
      end
    end
  end

endmodule : ee_fifo

// file: tb/ee_bus_master.sv
/*
  behavioural two-wire bus master that drives the memory slave in the bench.
  assumes the bench resolves sda from pull and the slave drive, with a
  pull-up; calls start on a clock edge so changes land 1 ns after it.
*/
`timescale 1ns/100ps
module ee_bus_master (
  input  wire logic clock,
  input  wire logic sda,
  output logic      scl,
  output logic      pull
);
  // bus idles with both lines high, scl stands still between frames
  initial begin
    scl  = 1'b1;
    pull = 1'b0;
  end

  // one 160 ns bit: 50 ns hold, 50 ns setup, sampled mid high phase
  task automatic bit_io(input logic b, output logic s);
    #50 pull = ~b;
    #50 scl = 1'b1;
    #30 s = sda;
    #30 scl = 1'b0;
  endtask : bit_io

  // start or repeated start: sda falls while scl is high
  task automatic start_cond();
    @(posedge clock);
    #1;
    if (scl === 1'b0) begin
      #50 pull = 1'b0;
      #50 scl = 1'b1;
    end
    #60 pull = 1'b1;
    #60 scl = 1'b0;
  endtask : start_cond

  // stop: sda rises while scl is high, bus then left idle
  task automatic stop_cond();
    @(posedge clock);
    #1;
    #50 pull = 1'b1;
    #50 scl = 1'b1;
    #60 pull = 1'b0;
    #60;
  endtask : stop_cond

  // byte out msb first, line released for the slave's ack slot
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask : send_byte

  // byte in; ack asks for the next byte, nack ends the read
  task automatic recv_byte(input logic more, output logic [7:0] d,
                           output logic rel);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(~more, rel);
  endtask : recv_byte
endmodule : ee_bus_master

// file: tb/tb_top.sv
/*
  self-checking bench for the two-wire memory slave with a bus master model.
  assumes a shortened write cycle so polling sees both busy and done.
*/
`timescale 1ns/100ps
module tb_top;
  localparam logic [3:0] CODE = ee_pkg::DEV_CODE_DEF;
  localparam int         TWC  = 800;

  logic clock, rst_n, scl, pull, sda, sda_out, sda_oe, wr_busy;
  int   mem [16];
  int   ptr, seed, failures, total_checks, i;
  logic ack;
  logic [7:0] a, d;

  // open-drain line: pull-up unless either party pulls it low
  assign sda = (sda_oe ? sda_out : 1'b1) & ~pull;

  ee_slave #(.DEV_CODE(CODE), .TWC_CYCLES(TWC),
             .FIFO_DEPTH(ee_pkg::FIFO_DEPTH)) i_dut (
    .clock(clock), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .wr_busy(wr_busy));

  ee_bus_master i_master (.clock(clock), .sda(sda), .scl(scl), .pull(pull));

  // 100 MHz system clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  // control byte: code, three random don't-care bits, direction
  function automatic logic [7:0] ctl(input logic rw);
    return {CODE, 3'($random(seed)), rw};
  endfunction : ctl

  // polling repeats start and control byte until the slave acks
  task automatic poll();
    logic pa;
    pa = 1'b0;
    for (int n = 0; n < 20 && pa !== 1'b1; n++) begin
      i_master.start_cond();
      i_master.send_byte(ctl(1'b0), pa);
      i_master.stop_cond();
      if (n == 0) check("busy poll", {7'h00, pa}, 8'h00);
    end
    check("poll ack", {7'h00, pa}, 8'h01);
    check("busy end", {7'h00, wr_busy}, 8'h00);
    if (pa !== 1'b1) stop_test();
  endtask : poll

  // write cycle must start; a read during it is refused, then poll
  task automatic wait_busy();
    logic ra;
    for (int n = 0; n < 20 && wr_busy !== 1'b1; n++) begin
      @(posedge clock);
      #1;
    end
    check("busy", {7'h00, wr_busy}, 8'h01);
    if (wr_busy !== 1'b1) stop_test();
    i_master.start_cond();
    i_master.send_byte(ctl(1'b1), ra);
    check("busy read", {7'h00, ra}, 8'h00);
    i_master.stop_cond();
    poll();
  endtask : wait_busy

  // start, write control byte and word address
  task automatic head(input logic [7:0] wa);
    logic ha;
    i_master.start_cond();
    i_master.send_byte(ctl(1'b0), ha);
    check("ctrl ack", {7'h00, ha}, 8'h01);
    i_master.send_byte(wa, ha);
    check("addr ack", {7'h00, ha}, 8'h01);
    ptr = wa[3:0];
  endtask : head

  task automatic write_cmd(input logic [7:0] wa, input logic [7:0] wd);
    logic wk;
    head(wa);
    i_master.send_byte(wd, wk);
    check("data ack", {7'h00, wk}, 8'h01);
    i_master.stop_cond();
    mem[wa[3:0]] = wd;
    wait_busy();
  endtask : write_cmd

  // read control byte, n bytes acked except the last, then stop
  task automatic read_run(input int n);
    logic rk, rel;
    logic [7:0] rd;
    i_master.send_byte(ctl(1'b1), rk);
    check("read ack", {7'h00, rk}, 8'h01);
    for (int k = 0; k < n; k++) begin
      i_master.recv_byte(k < n - 1, rd, rel);
      check("read data", rd, 8'(mem[ptr]));
      ptr = (ptr + 1) % 16;
    end
    check("release", {7'h00, rel}, 8'h01);
    i_master.stop_cond();
  endtask : read_run

  task automatic rand_read(input logic [7:0] ra, input int n);
    head(ra);
    i_master.start_cond();
    read_run(n);
  endtask : rand_read

  // hang guard
  initial begin
    repeat (90000) @(posedge clock);
    failures++;
    stop_test();
  end

  initial begin
    seed = 35;
    failures = 0;
    total_checks = 0;
    ptr = 0;
    rst_n = 1'b0;
    repeat (4) @(posedge clock);
    #1 rst_n = 1'b1;
    repeat (8) @(posedge clock);
    // every location written, upper address bits random
    for (i = 0; i < 16; i++) begin
      write_cmd({4'($random(seed)), 4'(i)}, 8'($random(seed)));
    end
    $display("test fill done");
    // sequential read across the top, then a current-address read
    rand_read({4'($random(seed)), 4'hE}, 4);
    i_master.start_cond();
    read_run(1);
    $display("test read forms done");
    // pointer stays at the written address after a byte write
    a = 8'($random(seed));
    write_cmd(a, 8'($random(seed)));
    i_master.start_cond();
    read_run(1);
    $display("test pointer after write done");
    // wrong device codes get no ack
    for (i = 1; i < 16; i = i * 2) begin
      i_master.start_cond();
      i_master.send_byte({CODE ^ 4'(i), 4'($random(seed))}, ack);
      check("foreign ack", {7'h00, ack}, 8'h00);
      i_master.stop_cond();
    end
    $display("test foreign code done");
    // stop after the address: nothing stored, no write cycle
    a = 8'($random(seed));
    head(a);
    i_master.stop_cond();
    repeat (20) @(posedge clock);
    #1;
    check("abort busy", {7'h00, wr_busy}, 8'h00);
    rand_read(a, 1);
    // two whole data bytes: the last one is kept
    head(a);
    i_master.send_byte(8'($random(seed)), ack);
    d = 8'($random(seed));
    i_master.send_byte(d, ack);
    check("extra ack", {7'h00, ack}, 8'h01);
    i_master.stop_cond();
    mem[a[3:0]] = d;
    wait_busy();
    rand_read(a, 1);
    // a partial second byte aborts the write
    head(a);
    i_master.send_byte(8'($random(seed)), ack);
    for (i = 0; i < 3; i++) i_master.bit_io(1'($random(seed)), ack);
    i_master.stop_cond();
    repeat (20) @(posedge clock);
    #1;
    check("partial busy", {7'h00, wr_busy}, 8'h00);
    rand_read(a, 1);
    $display("test aborts done");
    // open drain: the drive value never leaves the low level
    check("drive level", {7'h00, sda_out}, 8'h00);
    stop_test();
  end
endmodule : tb_top
